// file: logic/conv_ctrl_pkg.sv
// package: constants and types of the converter control block
package conv_ctrl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int OCP_TIME_MS = 1;
  localparam int OCP_CYC = OCP_TIME_MS * CYC_PER_MS;
  localparam int SS_STEP_MS = 1;
  localparam int SS_STEP_CYC = SS_STEP_MS * CYC_PER_MS;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam int AW = 9;
  localparam logic [6:0] IDX_VOUT1 = 7'h00;
  localparam logic [6:0] IDX_VOUT2 = 7'h01;
  localparam logic [6:0] IDX_VOUT3 = 7'h02;
  localparam logic [6:0] IDX_SS1 = 7'h10;
  localparam logic [6:0] IDX_SS2 = 7'h11;
  localparam logic [6:0] IDX_SS3 = 7'h12;
  localparam logic [6:0] IDX_MODE = 7'h20;
  localparam logic [6:0] IDX_ONOFF = 7'h30;
  localparam logic [6:0] IDX_ERR = 7'h40;
  localparam logic [6:0] IDX_PGOOD = 7'h50;

  // ==========================================================
  // reset values and fields
  localparam logic [4:0] RST_VOUT1 = 5'h0f;
  localparam logic [3:0] RST_VOUT2 = 4'h0c;
  localparam logic [2:0] RST_VOUT3 = 3'h5;
  localparam logic [3:0] RST_SS = 4'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [2:0] RST_ONOFF = 3'h0;
  localparam int ERR_TH_BIT = 4;

  // ==========================================================
  // per channel voltage scale in mV: base, step, default
  localparam logic [2:0][11:0] VBASE_MV = {12'haf0, 12'h4b0, 12'h2bc};
  localparam logic [2:0][11:0] VSTEP_MV = {12'h064, 12'h032, 12'h014};
  localparam logic [2:0][11:0] VDEF_MV = {12'hce4, 12'h708, 12'h3e8};

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_READY = 2'b01,
    ST_ERROR = 2'b10
  } fsm_t;

  typedef struct packed {
    logic [2:0] overcurrent_trip;
    logic [2:0] above_rise;
    logic [2:0] above_fall;
    logic thermal_trip;
    logic undervoltage;
    logic internal_reference_ok;
  } sense_t;

  typedef struct packed {
    logic run;
    logic fixed_pwm;
    logic discharge;
    logic [11:0] setpoint_mv;
  } chan_out_t;

endpackage

// file: logic/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  // ==========================================================
  // change accepted once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.q = (st_q.s2 & st_q.s3) | (st_q.q & (st_q.s2 ^ st_q.s3));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.q;

endmodule

// file: logic/conv_chan_ctrl.sv
// one converter channel: soft-start ramp, overcurrent timer, power good
`timescale 1ns/1ps
module conv_chan_ctrl #(
  parameter logic [11:0] VBASE = 12'h000,
  parameter logic [11:0] VSTEP = 12'h001,
  parameter logic [11:0] VDEF = 12'h001,
  parameter int OCP_DELAY_CYC = 1,
  parameter int SS_MS_CYC = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic on,
  input wire logic hold,
  input wire logic [4:0] vcode,
  input wire logic [3:0] ss_code,
  // comparators
  input wire logic oc,
  input wire logic rise,
  input wire logic fall,
  // results
  output logic oc_fire,
  output logic good,
  output logic [11:0] setpoint_mv
);

  typedef struct packed {
    logic [11:0] ramp;
    logic [23:0] acc;
    logic [19:0] oc_cnt;
    logic good;
  } chan_state_t;

  chan_state_t st_q;
  chan_state_t st_d;
  logic [11:0] target;
  logic [23:0] lim;
  logic [23:0] acc_n;
  logic oc_run;

  always_comb begin
    st_d = st_q;
    target = VBASE + 12'(vcode) * VSTEP;
    lim = 24'({1'b0, ss_code} + 5'h01) * 24'(SS_MS_CYC);
    acc_n = st_q.acc + 24'(VDEF);
    // default-voltage units per ms keep slope fixed
    if (!on) begin
      st_d.ramp = 12'h000;
      st_d.acc = 24'h000000;
    end else if (st_q.ramp >= target) begin
      st_d.ramp = target;
      st_d.acc = 24'h000000;
    end else if (acc_n >= lim) begin
      st_d.ramp = st_q.ramp + 12'h001;
      st_d.acc = acc_n - lim;
    end else begin
      st_d.acc = acc_n;
    end
    oc_run = on & oc & ~hold;
    if (!oc_run) begin
      st_d.oc_cnt = 20'h00000;
    end else if (st_q.oc_cnt != 20'(OCP_DELAY_CYC - 1)) begin
      st_d.oc_cnt = st_q.oc_cnt + 20'h00001;
    end
    oc_fire = oc_run & (st_q.oc_cnt == 20'(OCP_DELAY_CYC - 1));
    if (!on) begin
      st_d.good = 1'b0;
    end else if (!st_q.good && rise) begin
      st_d.good = 1'b1;
    end else if (st_q.good && !fall) begin
      st_d.good = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign good = st_q.good;
  assign setpoint_mv = st_q.ramp;

endmodule

// file: logic/converter_enable_protection_ctrl.sv
// top: enables, device states, protection and register slave
`timescale 1ns/1ps

module converter_enable_protection_ctrl #(
  parameter int OCP_DELAY_CYC = conv_ctrl_pkg::OCP_CYC,
  parameter int SS_MS_CYC = conv_ctrl_pkg::SS_STEP_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // register bus
  input wire logic [conv_ctrl_pkg::AW-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // control pins
  input wire logic MASTER_ENABLE_PIN,
  input wire logic CHAN1_ENABLE_PIN,
  input wire logic CHAN2_ENABLE_PIN,
  input wire logic CHAN3_ENABLE_PIN,
  input wire logic MODE_PIN,
  // comparators and supervisors
  input wire conv_ctrl_pkg::sense_t SENSE,
  // converter channel controls
  output conv_ctrl_pkg::chan_out_t [2:0] CHAN_OUT,
  // power good open-drain pins
  output logic POWER_GOOD_1_OUT,
  output logic POWER_GOOD_1_OE_N,
  output logic POWER_GOOD_2_OUT,
  output logic POWER_GOOD_2_OE_N,
  output logic POWER_GOOD_3_OUT,
  output logic POWER_GOOD_3_OE_N
);

  import conv_ctrl_pkg::*;

  typedef struct packed {
    fsm_t fsm;
    logic [4:0] vout1;
    logic [3:0] vout2;
    logic [2:0] vout3;
    logic [2:0][3:0] ss;
    logic [2:0] mode;
    logic [2:0] onoff;
    logic [2:0] err_oc;
    logic err_th;
    logic [2:0] run;
    logic [2:0] fixed;
    logic ack;
    logic [7:0] rdata;
  } ctl_state_t;

  localparam int SW = 17;

  ctl_state_t st_q;
  ctl_state_t st_d;

  logic [SW-1:0] raw_in;
  logic [SW-1:0] syn_in;
  logic master_enable_pin;
  logic [2:0] chan_enable_pin;
  logic mode_pin;
  sense_t sense;

  logic [2:0] oc_fire;
  logic [2:0] good;
  logic [2:0][11:0] setpoint;
  logic [2:0][4:0] vcode;

  logic ref_ok;
  logic serial_ok;
  logic [2:0] run_req;
  logic uvlo_act;
  logic th_armed;
  logic th_hit;
  logic oc_hit;
  logic req;
  logic [6:0] idx;
  logic wr_lo;
  logic [7:0] wd;

  // ==========================================================
  // input synchronisers
  // comparator results synchronised
  assign raw_in = {MASTER_ENABLE_PIN, CHAN3_ENABLE_PIN,
                   CHAN2_ENABLE_PIN, CHAN1_ENABLE_PIN,
                   MODE_PIN, SENSE};

  pin_sync #(
    .W(SW)
  ) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d(raw_in),
    .q(syn_in)
  );

  assign master_enable_pin = syn_in[16];
  assign chan_enable_pin = syn_in[15:13];
  assign mode_pin = syn_in[12];
  assign sense = syn_in[11:0];
  assign ref_ok = sense.internal_reference_ok;

  // ==========================================================
  // channels
  assign vcode[0] = st_q.vout1;
  assign vcode[1] = {1'b0, st_q.vout2};
  assign vcode[2] = {2'b00, st_q.vout3};

  for (genvar i = 0; i < 3; i++) begin : g_chan
    conv_chan_ctrl #(
      .VBASE(VBASE_MV[i]),
      .VSTEP(VSTEP_MV[i]),
      .VDEF(VDEF_MV[i]),
      .OCP_DELAY_CYC(OCP_DELAY_CYC),
      .SS_MS_CYC(SS_MS_CYC)
    ) u_chan (
      .clk(CLK),
      .rst_b(RST_B),
      .on(st_q.run[i]),
      .hold(th_armed & sense.thermal_trip),
      .vcode(vcode[i]),
      .ss_code(st_q.ss[i]),
      .oc(sense.overcurrent_trip[i]),
      .rise(sense.above_rise[i]),
      .fall(sense.above_fall[i]),
      .oc_fire(oc_fire[i]),
      .good(good[i]),
      .setpoint_mv(setpoint[i])
    );

    assign CHAN_OUT[i].run = st_q.run[i];
    assign CHAN_OUT[i].discharge = ~st_q.run[i];
    assign CHAN_OUT[i].fixed_pwm = st_q.fixed[i];
    assign CHAN_OUT[i].setpoint_mv = setpoint[i];
  end

  // ==========================================================
  // enable and protection terms
  // combined per-channel request
  assign run_req = {3{master_enable_pin}}
                   & (chan_enable_pin | st_q.onoff);
  assign uvlo_act = master_enable_pin & sense.undervoltage;
  // thermal armed by master, an enabled channel and the ready state
  assign th_armed = master_enable_pin & (|run_req)
                    & (st_q.fsm == ST_READY);
  assign th_hit = th_armed & sense.thermal_trip;
  assign oc_hit = ~th_hit & (st_q.fsm == ST_READY) & (|oc_fire);
  assign serial_ok = master_enable_pin & ref_ok
                     & (st_q.fsm != ST_STANDBY);

  // ==========================================================
  // bus decode
  assign req = READ | WRITE;
  assign idx = ADDRESS[8:2];
  assign wr_lo = WRITE & BYTEENABLE[0] & st_q.ack & serial_ok;
  assign wd = WRITEDATA[7:0];

  function automatic logic [7:0] rd_mux(input ctl_state_t s,
                                        input logic [6:0] a,
                                        input logic [2:0] g);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      IDX_VOUT1: r = {3'h0, s.vout1};
      IDX_VOUT2: r = {4'h0, s.vout2};
      IDX_VOUT3: r = {5'h00, s.vout3};
      IDX_SS1: r = {4'h0, s.ss[0]};
      IDX_SS2: r = {4'h0, s.ss[1]};
      IDX_SS3: r = {4'h0, s.ss[2]};
      IDX_MODE: r = {5'h00, s.mode};
      IDX_ONOFF: r = {5'h00, s.onoff};
      IDX_ERR: r = {3'h0, s.err_th, 1'b0, s.err_oc};
      IDX_PGOOD: r = {5'h00, g};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;

    // device states
    case (st_q.fsm)
      ST_STANDBY: begin
        if (master_enable_pin) begin
          st_d.fsm = ST_READY;
        end
      end
      ST_READY: begin
        if (th_hit || oc_hit) begin
          st_d.fsm = ST_ERROR;
        end
      end
      // only master low or reset leaves
      ST_ERROR: begin
        st_d.fsm = ST_ERROR;
      end
      default: begin
        st_d.fsm = ST_STANDBY;
      end
    endcase
    if (!master_enable_pin) begin
      st_d.fsm = ST_STANDBY;
    end

    if (th_hit) begin
      st_d.err_th = 1'b1;
    end else if (oc_hit) begin
      st_d.err_oc = st_q.err_oc | oc_fire;
    end
    if (!master_enable_pin) begin
      st_d.err_oc = 3'h0;
      st_d.err_th = 1'b0;
    end

    if (st_d.fsm == ST_READY && ref_ok && !uvlo_act) begin
      st_d.run = run_req;
    end else begin
      st_d.run = 3'h0;
    end

    // fixed pulse-width needs pin low and bit 0
    st_d.fixed = ~({3{mode_pin}} | st_q.mode);

    // bus handshake, answer one cycle after the request
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack) begin
      st_d.rdata = serial_ok ? rd_mux(st_q, idx, good) : 8'h00;
    end

    // writes only inside the access window
    if (wr_lo) begin
      case (idx)
        IDX_VOUT1: st_d.vout1 = wd[4:0];
        IDX_VOUT2: st_d.vout2 = wd[3:0];
        IDX_VOUT3: st_d.vout3 = wd[2:0];
        IDX_SS1: st_d.ss[0] = wd[3:0];
        IDX_SS2: st_d.ss[1] = wd[3:0];
        IDX_SS3: st_d.ss[2] = wd[3:0];
        IDX_MODE: st_d.mode = wd[2:0];
        IDX_ONOFF: st_d.onoff = wd[2:0];
        default: st_d.onoff = st_q.onoff;
      endcase
    end

    // reference collapse resets the writable registers, not the error flags
    if (!ref_ok) begin
      st_d.vout1 = RST_VOUT1;
      st_d.vout2 = RST_VOUT2;
      st_d.vout3 = RST_VOUT3;
      st_d.ss = {3{RST_SS}};
      st_d.mode = RST_MODE;
      st_d.onoff = RST_ONOFF;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q.fsm <= ST_STANDBY;
      st_q.vout1 <= RST_VOUT1;
      st_q.vout2 <= RST_VOUT2;
      st_q.vout3 <= RST_VOUT3;
      st_q.ss <= {3{RST_SS}};
      st_q.mode <= RST_MODE;
      st_q.onoff <= RST_ONOFF;
      st_q.err_oc <= 3'h0;
      st_q.err_th <= 1'b0;
      st_q.run <= 3'h0;
      st_q.fixed <= 3'h7;
      st_q.ack <= 1'b0;
      st_q.rdata <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign WAITREQUEST = req & ~st_q.ack;
  assign READDATA = {24'h000000, st_q.rdata};

  // released (high) only while power is good
  assign POWER_GOOD_1_OUT = 1'b0;
  assign POWER_GOOD_2_OUT = 1'b0;
  assign POWER_GOOD_3_OUT = 1'b0;
  assign POWER_GOOD_1_OE_N = good[0];
  assign POWER_GOOD_2_OE_N = good[1];
  assign POWER_GOOD_3_OE_N = good[2];

endmodule

// file: sim/conv_sense_model.sv
// sense model: converter comparators and supervisors
`timescale 1ns/1ps
module conv_sense_model (
  // converter state
  input wire conv_ctrl_pkg::chan_out_t [2:0] chan_out,
  // commanded conditions
  input wire logic [2:0] oc,
  input wire logic [1:0] lvl,
  input wire logic th,
  input wire logic uv,
  input wire logic ref_ok,
  // comparator results
  output conv_ctrl_pkg::sense_t sense
);
  import conv_ctrl_pkg::*;
  logic [2:0] on;
  assign on = {chan_out[2].run, chan_out[1].run, chan_out[0].run};
  assign sense.overcurrent_trip = oc & on;
  assign sense.thermal_trip = th;
  assign sense.undervoltage = uv;
  assign sense.internal_reference_ok = ref_ok;
  assign sense.above_rise = on & {3{lvl == 2'h2}};
  assign sense.above_fall = on & {3{lvl != 2'h0}};
endmodule

// file: sim/converter_enable_protection_ctrl_asserts.sv
// checker: port properties of the converter control block
`timescale 1ns/1ps
module converter_enable_protection_ctrl_asserts
  import conv_ctrl_pkg::*;
#(
  parameter int OCP_DELAY_CYC = 1,
  parameter int SS_MS_CYC = 1
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // bus
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // pins
  input wire logic MASTER_ENABLE_PIN,
  input wire logic MODE_PIN,
  input wire conv_ctrl_pkg::sense_t SENSE,
  // outputs
  input wire conv_ctrl_pkg::chan_out_t [2:0] CHAN_OUT,
  input wire logic POWER_GOOD_1_OE_N
);
  logic [2:0] run;
  assign run = {CHAN_OUT[2].run, CHAN_OUT[1].run, CHAN_OUT[0].run};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ========
  // properties
  property p_men;
    !MASTER_ENABLE_PIN [*7] |-> run == 3'h0;
  endproperty
  a_men: assert property (p_men)
    else $error("run with master low");
  property p_dis;
    (CHAN_OUT[0].discharge != CHAN_OUT[0].run) &&
    (CHAN_OUT[1].discharge != CHAN_OUT[1].run) &&
    (CHAN_OUT[2].discharge != CHAN_OUT[2].run);
  endproperty
  a_dis: assert property (p_dis)
    else $error("discharge not inverse of run");
  property p_th;
    SENSE.thermal_trip [*8] |-> run == 3'h0;
  endproperty
  a_th: assert property (p_th)
    else $error("run during thermal trip");
  property p_uv;
    SENSE.undervoltage [*8] |-> run == 3'h0;
  endproperty
  a_uv: assert property (p_uv)
    else $error("run during undervoltage");
  property p_mode;
    MODE_PIN [*7] |-> !(CHAN_OUT[0].fixed_pwm || CHAN_OUT[1].fixed_pwm ||
      CHAN_OUT[2].fixed_pwm);
  endproperty
  a_mode: assert property (p_mode)
    else $error("fixed mode with mode pin high");
  property p_pg;
    !run[0] [*3] |-> !POWER_GOOD_1_OE_N;
  endproperty
  a_pg: assert property (p_pg)
    else $error("power good while off");
  property p_rd0;
    !MASTER_ENABLE_PIN [*8] ##0 (READ && !WAITREQUEST) |-> READDATA == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0)
    else $error("read data with master low");
  property p_ramp;
    CHAN_OUT[0].run && $past(CHAN_OUT[0].run) |->
      CHAN_OUT[0].setpoint_mv <= $past(CHAN_OUT[0].setpoint_mv) + 12'h001;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("setpoint jumps");
  property p_bus;
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus answer late");
endmodule
bind converter_enable_protection_ctrl
  converter_enable_protection_ctrl_asserts #(
  .OCP_DELAY_CYC(OCP_DELAY_CYC),
  .SS_MS_CYC(SS_MS_CYC)
) chk (
  .CLK(CLK), .RST_B(RST_B), .READ(READ), .WRITE(WRITE),
  .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
  .MASTER_ENABLE_PIN(MASTER_ENABLE_PIN), .MODE_PIN(MODE_PIN),
  .SENSE(SENSE), .CHAN_OUT(CHAN_OUT), .POWER_GOOD_1_OE_N(POWER_GOOD_1_OE_N)
);

// file: sim/converter_enable_protection_ctrl_tb.sv
// testbench for the converter control block
`timescale 1ns/1ps
`define CK(a, e) begin n_checks++; if ((a) !== (e)) begin \
  err_count++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module converter_enable_protection_ctrl_tb;
  import conv_ctrl_pkg::*;
  localparam int OCD = 20;
  localparam int SSC = 2000;
  logic clk, rst_b, rd, wr, men, mpin, th, uv, ref_ok, wt;
  logic [AW-1:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] be, ssv;
  logic [2:0] cpin, oc, oen, pgo;
  logic [1:0] lvl;
  logic [7:0] lf;
  sense_t sense;
  chan_out_t [2:0] co;
  int err_count, n_checks, k, t;
  converter_enable_protection_ctrl #(.OCP_DELAY_CYC(OCD), .SS_MS_CYC(SSC))
    dut (
    .CLK(clk), .RST_B(rst_b), .ADDRESS(adr), .READ(rd), .WRITE(wr),
    .WRITEDATA(wdat), .BYTEENABLE(be), .READDATA(rdat), .WAITREQUEST(wt),
    .MASTER_ENABLE_PIN(men), .CHAN1_ENABLE_PIN(cpin[0]),
    .CHAN2_ENABLE_PIN(cpin[1]), .CHAN3_ENABLE_PIN(cpin[2]), .MODE_PIN(mpin),
    .SENSE(sense), .CHAN_OUT(co), .POWER_GOOD_1_OUT(pgo[0]),
    .POWER_GOOD_1_OE_N(oen[0]), .POWER_GOOD_2_OUT(pgo[1]),
    .POWER_GOOD_2_OE_N(oen[1]), .POWER_GOOD_3_OUT(pgo[2]),
    .POWER_GOOD_3_OE_N(oen[2]));
  conv_sense_model plant (.chan_out(co), .oc(oc), .lvl(lvl), .th(th),
    .uv(uv), .ref_ok(ref_ok), .sense(sense));
  // ========
  // helpers
  function automatic logic [7:0] nx(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [2:0] runs();
    return {co[2].run, co[1].run, co[0].run};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d);
    @(posedge clk);
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    wr <= w;
    rd <= !w;
    // wait for the answer; only the watchdog ends a hang
    do @(negedge clk); while (wt !== 1'b0);
    @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rk(input logic [6:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    `CK(q, {24'h0, e})
  endtask
  task automatic ck3(input logic [2:0] e);
    @(negedge clk);
    `CK(runs(), e)
    `CK({co[2].discharge, co[1].discharge, co[0].discharge}, ~e)
    @(posedge clk);
  endtask
  task automatic pg(input logic [1:0] l, input logic [2:0] e);
    lvl <= l;
    cyc(10);
    @(negedge clk);
    `CK(oen, e)
    `CK(pgo, 3'h0)
    @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ========
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    conclude();
  end
  // ========
  // scenarios
  initial begin
    rst_b = 0; rd = 0; wr = 0; adr = '0; wdat = '0; be = 4'h1; men = 0;
    mpin = 0; cpin = 0; oc = 0; lvl = 0; th = 0; uv = 0; ref_ok = 1;
    lf = 8'h3b;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    cyc(10);
    bus(1'b1, IDX_ONOFF, 8'h07);
    rk(IDX_ONOFF, 8'h00);
    men <= 1'b1;
    cyc(10);
    rk(IDX_ONOFF, 8'h00);
    rk(IDX_VOUT1, 8'h0f);
    rk(IDX_VOUT2, 8'h0c);
    rk(IDX_VOUT3, 8'h05);
    rk(IDX_MODE, 8'h00);
    rk(7'h60, 8'h00);
    bus(1'b1, IDX_ERR, 8'h17);
    rk(IDX_ERR, 8'h00);
    be <= 4'h0;
    bus(1'b1, IDX_SS2, 8'h05);
    be <= 4'h1;
    rk(IDX_SS2, 8'h00);
    bus(1'b1, IDX_ONOFF, 8'h0f);
    rk(IDX_ONOFF, 8'h07);
    lf = nx(lf);
    bus(1'b1, IDX_VOUT2, lf);
    rk(IDX_VOUT2, {4'h0, lf[3:0]});
    bus(1'b1, IDX_VOUT3, lf);
    rk(IDX_VOUT3, {5'h00, lf[2:0]});
    bus(1'b1, IDX_SS3, lf);
    rk(IDX_SS3, {4'h0, lf[3:0]});
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      bus(1'b1, IDX_ONOFF, {5'h0, lf[2:0]});
      cpin <= lf[5:3];
      cyc(8);
      ck3(lf[2:0] | lf[5:3]);
    end
    men <= 1'b0;
    cyc(8);
    ck3(3'h0);
    men <= 1'b1;
    cyc(10);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, IDX_MODE, {5'h0, {3{m[0]}}});
      mpin <= m[1];
      cyc(8);
      @(negedge clk);
      `CK(co[1].fixed_pwm, !m[1] && !m[0])
    end
    bus(1'b1, IDX_MODE, 8'h02);
    mpin <= 1'b0;
    cyc(8);
    @(negedge clk);
    `CK({co[2].fixed_pwm, co[1].fixed_pwm, co[0].fixed_pwm}, 3'h5)
    bus(1'b1, IDX_ONOFF, 8'h00);
    cpin <= 3'h7;
    oc <= 3'h2;
    cyc(OCD / 2);
    oc <= 3'h0;
    ck3(3'h7);
    oc <= 3'h2;
    cyc(OCD + 10);
    ck3(3'h0);
    rk(IDX_ERR, 8'h02);
    oc <= 3'h0;
    cyc(10);
    ck3(3'h0);
    men <= 1'b0;
    cyc(8);
    men <= 1'b1;
    cyc(10);
    ck3(3'h7);
    rk(IDX_ERR, 8'h00);
    oc <= 3'h1;
    cyc(OCD / 2);
    oc <= 3'h0;
    th <= 1'b1;
    cyc(10);
    ck3(3'h0);
    rk(IDX_ERR, 8'h10);
    th <= 1'b0;
    men <= 1'b0;
    cpin <= 3'h0;
    cyc(8);
    men <= 1'b1;
    th <= 1'b1;
    cyc(10);
    th <= 1'b0;
    cpin <= 3'h7;
    cyc(10);
    ck3(3'h7);
    uv <= 1'b1;
    cyc(10);
    ck3(3'h0);
    rk(IDX_ERR, 8'h00);
    uv <= 1'b0;
    cyc(10);
    ck3(3'h7);
    bus(1'b1, IDX_ONOFF, 8'h07);
    cpin <= 3'h0;
    uv <= 1'b1;
    ref_ok <= 1'b0;
    cyc(10);
    ref_ok <= 1'b1;
    uv <= 1'b0;
    cyc(10);
    ck3(3'h0);
    rk(IDX_ONOFF, 8'h00);
    cpin <= 3'h7;
    cyc(10);
    pg(2'h2, 3'h7);
    pg(2'h1, 3'h7);
    pg(2'h0, 3'h0);
    pg(2'h1, 3'h0);
    pg(2'h2, 3'h7);
    rk(IDX_PGOOD, 8'h07);
    cpin <= 3'h0;
    pg(2'h2, 3'h0);
    bus(1'b1, IDX_VOUT1, 8'h05);
    for (int s = 0; s < 2; s++) begin
      lf = nx(lf);
      ssv = s ? lf[3:0] : 4'h0;
      bus(1'b1, IDX_SS1, {4'h0, ssv});
      cyc(20);
      cpin <= 3'h1;
      t = (ssv + 1) * SSC * 800 / 1000;
      k = 0;
      while (co[0].setpoint_mv !== 12'h320 && k < 40000) begin
        @(negedge clk);
        k++;
      end
      `CK(k >= t * 9 / 10 && k <= t * 11 / 10, 1'b1)
      `CK(co[0].setpoint_mv, 12'h320)
      cyc(1);
      cpin <= 3'h0;
      cyc(20);
    end
    conclude();
  end
endmodule
